// ---- rtl/pcp_command_panel.sv ----
// pump controller: serial command interpreter, front panel and axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.svh"
// Summary of operation
// - The serial link runs at 9600 baud with 8 data bits, no parity, one stop bit, no flow control.
// - The pump-on command starts the drive with the current settings.
// - The pump-off command stops the drive.
// - The sine form command selects the sinusoidal form.
// - The rectangular form command selects the rectangular form.
// - The shaped form command selects the specially shaped form.
// - An enter key on its own sends back a report of all present settings.
// - Each run switch press toggles drive and run indicator together; a pump-on or pump-off command in the same cycle takes precedence.
// - The save switch stores the present frequency, amplitude and form.
// - The signal switch cycles shaped, rectangular, sine.
// - Frequency switch up raises and down lowers the frequency.
// - Amplitude switch up raises and down lowers the amplitude.
// - Settings may change while the pump runs.
module pcp_command_panel
    import pcp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        serRxd,
    output logic             serTxd,
    input  wire logic        swRun,
    input  wire logic        swSave,
    input  wire logic        swSignal,
    input  wire logic        swFreqUp,
    input  wire logic        swFreqDn,
    input  wire logic        swAmpUp,
    input  wire logic        swAmpDn,
    output logic             pumpDrive,
    output logic             runLed,
    output logic [8:0]       freqHz,
    output logic [7:0]       ampVolts,
    output logic [1:0]       signalForm,
    output logic [8:0]       savedFreq,
    output logic [7:0]       savedAmp,
    output logic [1:0]       savedForm,
    output logic             saveStrobe,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    function automatic logic isDigit(input logic [7:0] c);
        return (c >= `PCP_CH_0) && (c <= `PCP_CH_9);
    endfunction : isDigit

    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'ha) ? (`PCP_CH_0 + {4'h0, n}) : (`PCP_CH_LA + {4'h0, n} - 8'h0a);
    endfunction : hexChar

    // pin synchronisers: 3 stages, a change counts once stages 2 and 3 agree
    logic [7:0] syn0_q, syn1_q, syn2_q, pinLvl_q, pinPrev_q;
    logic [7:0] pinRaw;
    assign pinRaw = {serRxd, swRun, swSave, swSignal, swFreqUp, swFreqDn, swAmpUp, swAmpDn};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            syn0_q    <= 8'h80; // idle levels
            syn1_q    <= 8'h80;
            syn2_q    <= 8'h80;
            pinLvl_q  <= 8'h80;
            pinPrev_q <= 8'h80;
        end else begin
            syn0_q    <= pinRaw;
            syn1_q    <= syn0_q;
            syn2_q    <= syn1_q;
            pinLvl_q  <= (syn1_q & syn2_q) | (pinLvl_q & (syn1_q ^ syn2_q));
            pinPrev_q <= pinLvl_q;
        end
    end
    logic [6:0] press;
    assign press = pinLvl_q[6:0] & ~pinPrev_q[6:0];
    logic rxLvl;
    assign rxLvl = pinLvl_q[7];

    // serial receiver
    pcp_ser_t   rxSt_q;
    logic [11:0] rxCnt_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxSh_q;
    logic       rxStb_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxSt_q  <= PCP_SER_IDLE;
            rxCnt_q <= 12'h000;
            rxBit_q <= 3'h0;
            rxSh_q  <= 8'h00;
            rxStb_q <= 1'b0;
        end else begin
            rxStb_q <= 1'b0;
            if (rxCnt_q != 12'h000) begin
                rxCnt_q <= rxCnt_q - 12'h001;
            end else begin
                unique case (rxSt_q)
                    PCP_SER_IDLE: begin
                        if (!rxLvl) begin
                            rxSt_q  <= PCP_SER_START;
                            rxCnt_q <= 12'(`PCP_HALF_CYC);
                        end
                    end
                    PCP_SER_START: begin // recheck mid start bit to reject glitches
                        rxSt_q  <= rxLvl ? PCP_SER_IDLE : PCP_SER_DATA;
                        rxCnt_q <= 12'(`PCP_BIT_CYC);
                        rxBit_q <= 3'h0;
                    end
                    PCP_SER_DATA: begin // lsb first, 8 bits
                        rxSh_q  <= {rxLvl, rxSh_q[7:1]};
                        rxCnt_q <= 12'(`PCP_BIT_CYC);
                        rxBit_q <= rxBit_q + 3'h1;
                        if (rxBit_q == `PCP_DATA_BITS) rxSt_q <= PCP_SER_STOP;
                    end
                    PCP_SER_STOP: begin // bad stop bit drops the byte
                        rxStb_q <= rxLvl;
                        rxSt_q  <= PCP_SER_IDLE;
                    end
                endcase
            end
        end
    end

    // command line collector
    logic [2:0]  len_q;
    logic [7:0]  c0_q, c1_q, c2_q, c3_q;
    logic [11:0] acc_q;
    logic        numOk_q;
    logic        isEnter;
    logic [14:0] accMul;
    assign isEnter = rxStb_q && (rxSh_q == `PCP_CH_CR);
    assign accMul  = {acc_q, 3'h0} + {2'h0, acc_q, 1'h0} + {7'h00, rxSh_q - `PCP_CH_0};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            len_q   <= 3'h0;
            c0_q    <= 8'h00;
            c1_q    <= 8'h00;
            c2_q    <= 8'h00;
            c3_q    <= 8'h00;
            acc_q   <= 12'h000;
            numOk_q <= 1'b1;
        end else if (isEnter) begin
            len_q   <= 3'h0; // a line ends only at the enter key
            acc_q   <= 12'h000;
            numOk_q <= 1'b1;
        end else if (rxStb_q && rxSh_q != `PCP_CH_LF) begin
            if (len_q != 3'h7) len_q <= len_q + 3'h1;
            if (len_q == 3'h0) c0_q <= rxSh_q;
            if (len_q == 3'h1) c1_q <= rxSh_q;
            if (len_q == 3'h2) c2_q <= rxSh_q;
            if (len_q == 3'h3) c3_q <= rxSh_q;
            if (len_q != 3'h0) begin
                numOk_q <= numOk_q & isDigit(rxSh_q);
                acc_q   <= (acc_q >= `PCP_ACC_SAT) ? acc_q : accMul[11:0];
            end
        end
    end

    // decode at the enter key
    logic cmdOn, cmdOff, cmdFreq, cmdAmp, cmdSine, cmdRect, cmdShaped, cmdReport, twoCh;
    assign twoCh     = isEnter && (len_q == 3'h2) && (c0_q == `PCP_CH_M);
    assign cmdOn     = isEnter && (len_q == 3'h3) && c0_q == `PCP_CH_LB && c1_q == `PCP_CH_LO
                       && c2_q == `PCP_CH_LN;
    assign cmdOff    = isEnter && (len_q == 3'h4) && c0_q == `PCP_CH_LB && c1_q == `PCP_CH_LO
                       && c2_q == `PCP_CH_LF_ && c3_q == `PCP_CH_LF_;
    assign cmdSine   = twoCh && (c1_q == `PCP_CH_S);
    assign cmdRect   = twoCh && (c1_q == `PCP_CH_R);
    assign cmdShaped = twoCh && (c1_q == `PCP_CH_C);
    // non-numeric values and out-of-range values below 4096 are dropped silently; larger ones wrap at 4096 or freeze once past 1000, and may land in range
    assign cmdFreq   = isEnter && len_q >= 3'h2 && c0_q == `PCP_CH_F && numOk_q
                       && acc_q >= 12'(`PCP_FREQ_MIN) && acc_q <= 12'(`PCP_FREQ_MAX);
    assign cmdAmp    = isEnter && len_q >= 3'h2 && c0_q == `PCP_CH_A && numOk_q
                       && acc_q >= 12'(`PCP_AMP_MIN) && acc_q <= 12'(`PCP_AMP_MAX);
    assign cmdReport = isEnter && (len_q == 3'h0);

    // axi4-lite write side: address and data latched in either order
    logic        awHave_q, wHave_q;
    logic [4:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wrEn;
    assign s_axi_awready = !awHave_q;
    assign s_axi_wready  = !wHave_q;
    assign wrEn = awHave_q && wHave_q && !s_axi_bvalid;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            awAddr_q     <= 5'h00;
            wData_q      <= 32'h00000000;
            wStrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PCP_RESP_OK;
        end else begin
            if (s_axi_awvalid && !awHave_q) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHave_q) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrEn) begin
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q > `PCP_OFS_FORM) ? `PCP_RESP_ERR : `PCP_RESP_OK;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic wrCtrl, wrFreq, wrAmp, wrForm;
    assign wrCtrl = wrEn && awAddr_q == `PCP_OFS_CTRL && wStrb_q[0];
    assign wrFreq = wrEn && awAddr_q == `PCP_OFS_FREQ && wStrb_q[1:0] == 2'h3
                    && wData_q[8:0] >= `PCP_FREQ_MIN && wData_q[8:0] <= `PCP_FREQ_MAX
                    && wData_q[31:9] == 23'h000000;
    assign wrAmp  = wrEn && awAddr_q == `PCP_OFS_AMP && wStrb_q[0]
                    && wData_q[7:0] >= `PCP_AMP_MIN && wData_q[7:0] <= `PCP_AMP_MAX;
    assign wrForm = wrEn && awAddr_q == `PCP_OFS_FORM && wStrb_q[0]
                    && wData_q[1:0] != 2'h3;

    // run state: panel toggles, serial sets and clears, drive and led tied together
    logic run_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) run_q <= 1'b0;
        else if (cmdOn) run_q <= 1'b1;
        else if (cmdOff) run_q <= 1'b0;
        else if (press[6]) run_q <= !run_q;
        else if (wrCtrl) run_q <= wData_q[`PCP_CTRL_RUN];
    end
    assign pumpDrive = run_q;
    assign runLed    = run_q;

    // frequency, changes allowed while running
    logic [8:0] freq_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) freq_q <= `PCP_FREQ_RST;
        else if (cmdFreq) freq_q <= acc_q[8:0];
        else if (press[3] && freq_q != `PCP_FREQ_MAX) freq_q <= freq_q + 9'h001;
        else if (press[2] && freq_q != `PCP_FREQ_MIN) freq_q <= freq_q - 9'h001;
        else if (wrFreq) freq_q <= wData_q[8:0];
    end

    // amplitude, clamped at the ends of its range
    logic [7:0] amp_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) amp_q <= `PCP_AMP_RST;
        else if (cmdAmp) amp_q <= acc_q[7:0];
        else if (press[1] && amp_q != `PCP_AMP_MAX) amp_q <= amp_q + 8'h01;
        else if (press[0] && amp_q != `PCP_AMP_MIN) amp_q <= amp_q - 8'h01;
        else if (wrAmp) amp_q <= wData_q[7:0];
    end

    // signal form
    pcp_form_t form_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) form_q <= PCP_FORM_SINE;
        else if (cmdSine) form_q <= PCP_FORM_SINE;
        else if (cmdRect) form_q <= PCP_FORM_RECT;
        else if (cmdShaped) form_q <= PCP_FORM_SHAPED;
        else if (press[4]) begin // shaped -> rect -> sine -> shaped
            unique case (form_q)
                PCP_FORM_SHAPED: form_q <= PCP_FORM_RECT;
                PCP_FORM_RECT:   form_q <= PCP_FORM_SINE;
                default:         form_q <= PCP_FORM_SHAPED;
            endcase
        end else if (wrForm) form_q <= pcp_form_t'(wData_q[1:0]);
    end
    assign freqHz     = freq_q;
    assign ampVolts   = amp_q;
    assign signalForm = form_q;

    // save copy; saveStrobe lets an outside nonvolatile store take it
    logic doSave;
    assign doSave = press[5] || (wrCtrl && wData_q[`PCP_CTRL_SAVE]);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            savedFreq  <= `PCP_FREQ_RST;
            savedAmp   <= `PCP_AMP_RST;
            savedForm  <= PCP_FORM_SINE;
            saveStrobe <= 1'b0;
        end else begin
            saveStrobe <= doSave;
            if (doSave) begin
                savedFreq <= freq_q;
                savedAmp  <= amp_q;
                savedForm <= form_q;
            end
        end
    end

    // report text and serial transmitter; a report asked for mid-report is dropped
    logic        repBusy_q;
    logic [3:0]  repIdx_q;
    pcp_ser_t    txSt_q;
    logic [11:0] txCnt_q;
    logic [2:0]  txBit_q;
    logic [7:0]  txSh_q;
    logic [7:0]  repChar;
    always_comb begin
        repChar = `PCP_CH_SP;
        unique case (repIdx_q)
            4'h0: repChar = `PCP_CH_F;
            4'h1: repChar = hexChar({3'h0, freq_q[8]});
            4'h2: repChar = hexChar(freq_q[7:4]);
            4'h3: repChar = hexChar(freq_q[3:0]);
            4'h5: repChar = `PCP_CH_A;
            4'h6: repChar = hexChar(amp_q[7:4]);
            4'h7: repChar = hexChar(amp_q[3:0]);
            4'h9: repChar = `PCP_CH_M;
            4'ha: repChar = (form_q == PCP_FORM_SINE) ? `PCP_CH_S :
                            (form_q == PCP_FORM_RECT) ? `PCP_CH_R : `PCP_CH_C;
            4'hc: repChar = `PCP_CH_B;
            4'hd: repChar = hexChar({3'h0, run_q});
            4'he: repChar = `PCP_CH_CR;
            4'hf: repChar = `PCP_CH_LF;
            default: repChar = `PCP_CH_SP;
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            repBusy_q <= 1'b0;
            repIdx_q  <= 4'h0;
            txSt_q    <= PCP_SER_IDLE;
            txCnt_q   <= 12'h000;
            txBit_q   <= 3'h0;
            txSh_q    <= 8'h00;
            serTxd    <= 1'b1;
        end else begin
            if (cmdReport && !repBusy_q) begin
                repBusy_q <= 1'b1;
                repIdx_q  <= 4'h0;
            end
            if (txCnt_q != 12'h000) begin
                txCnt_q <= txCnt_q - 12'h001;
            end else begin
                unique case (txSt_q)
                    PCP_SER_IDLE: begin
                        if (repBusy_q) begin
                            txSh_q  <= repChar;
                            serTxd  <= 1'b0;
                            txSt_q  <= PCP_SER_START;
                            txCnt_q <= 12'(`PCP_BIT_CYC - 1);
                        end
                    end
                    PCP_SER_START: begin
                        serTxd  <= txSh_q[0];
                        txSh_q  <= {1'b1, txSh_q[7:1]};
                        txBit_q <= 3'h0;
                        txSt_q  <= PCP_SER_DATA;
                        txCnt_q <= 12'(`PCP_BIT_CYC - 1);
                    end
                    PCP_SER_DATA: begin // data bits 1 to 7 then one stop bit
                        serTxd  <= (txBit_q == `PCP_DATA_BITS) ? 1'b1 : txSh_q[0];
                        txSh_q  <= {1'b1, txSh_q[7:1]};
                        txBit_q <= txBit_q + 3'h1;
                        if (txBit_q == `PCP_DATA_BITS) txSt_q <= PCP_SER_STOP;
                        txCnt_q <= 12'(`PCP_BIT_CYC - 1);
                    end
                    PCP_SER_STOP: begin
                        txSt_q   <= PCP_SER_IDLE;
                        repIdx_q <= repIdx_q + 4'h1;
                        if (repIdx_q == `PCP_REP_LAST) repBusy_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // axi4-lite read side
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PCP_RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PCP_RESP_OK;
            unique case (s_axi_araddr)
                `PCP_OFS_CTRL: s_axi_rdata <= {31'h00000000, run_q};
                `PCP_OFS_FREQ: s_axi_rdata <= {23'h000000, freq_q};
                `PCP_OFS_AMP:  s_axi_rdata <= {24'h000000, amp_q};
                `PCP_OFS_FORM: s_axi_rdata <= {30'h00000000, form_q};
                `PCP_OFS_STAT: s_axi_rdata <= {29'h00000000, repBusy_q, rxSt_q != PCP_SER_IDLE,
                                               run_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PCP_RESP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : pcp_command_panel
`default_nettype wire

// ---- rtl/pcp_defines.svh ----
// constants for the pump command panel
`ifndef PCP_DEFINES_SVH
`define PCP_DEFINES_SVH
`define PCP_CLK_HZ     20000000
`define PCP_BAUD       9600
`define PCP_BIT_CYC    (`PCP_CLK_HZ / `PCP_BAUD)
`define PCP_HALF_CYC   (`PCP_BIT_CYC / 2)
`define PCP_DATA_BITS  3'h7
`define PCP_CH_CR      8'h0d
`define PCP_CH_LF      8'h0a
`define PCP_CH_SP      8'h20
`define PCP_CH_0       8'h30
`define PCP_CH_9       8'h39
`define PCP_CH_LA      8'h61
`define PCP_CH_A       8'h41
`define PCP_CH_B       8'h42
`define PCP_CH_F       8'h46
`define PCP_CH_M       8'h4d
`define PCP_CH_C       8'h43
`define PCP_CH_R       8'h52
`define PCP_CH_S       8'h53
`define PCP_CH_LB      8'h62
`define PCP_CH_LO      8'h6f
`define PCP_CH_LN      8'h6e
`define PCP_CH_LF_     8'h66
`define PCP_FREQ_MIN   9'h001
`define PCP_FREQ_MAX   9'h12c
`define PCP_AMP_MIN    8'h01
`define PCP_AMP_MAX    8'hfa
`define PCP_FREQ_RST   9'h064
`define PCP_AMP_RST    8'h64
`define PCP_ACC_SAT    12'h3e8
`define PCP_REP_LAST   4'hf
`define PCP_OFS_CTRL   5'h00
`define PCP_OFS_FREQ   5'h04
`define PCP_OFS_AMP    5'h08
`define PCP_OFS_FORM   5'h0c
`define PCP_OFS_STAT   5'h10
`define PCP_CTRL_RUN   0
`define PCP_CTRL_SAVE  1
`define PCP_RESP_OK    2'h0
`define PCP_RESP_ERR   2'h2
`endif

// ---- rtl/pcp_pkg.sv ----
// types for the pump command panel
package pcp_pkg;
    // signal form encoding, also the panel cycling order
    typedef enum logic [1:0] {
        PCP_FORM_SHAPED = 2'h0,
        PCP_FORM_RECT   = 2'h1,
        PCP_FORM_SINE   = 2'h2
    } pcp_form_t;
    // serial frame states, gray along idle-start-data-stop
    typedef enum logic [1:0] {
        PCP_SER_IDLE  = 2'h0,
        PCP_SER_START = 2'h1,
        PCP_SER_DATA  = 2'h3,
        PCP_SER_STOP  = 2'h2
    } pcp_ser_t;
endpackage : pcp_pkg

// ---- tb/pcp_host_term.sv ----
// serial terminal model on the host side of the command link
`timescale 1ns/1ps
`default_nettype none
module pcp_host_term (
    output logic rxd
);
    localparam int BitNs = 104167; // one bit at 9600 baud
    // line idles high between frames
    initial rxd = 1'b1;
    // 8n1 frame, lsb first, no flow control
    task automatic send(input string s);
        byte c;
        for (int i = 0; i < s.len(); i++) begin
            c = s[i];
            rxd = 1'b0;
            #(BitNs);
            for (int b = 0; b < 8; b++) begin
                rxd = c[b];
                #(BitNs);
            end
            rxd = 1'b1;
            #(BitNs);
        end
    endtask : send
endmodule : pcp_host_term
`default_nettype wire

// ---- tb/pcp_panel_chk_props.sv ----
// concurrent checks on the pump command panel ports
`timescale 1ns/1ps
`default_nettype none
module pcp_panel_chk (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       swRun,
    input wire logic       swSignal,
    input wire logic       swFreqDn,
    input wire logic       pumpDrive,
    input wire logic       runLed,
    input wire logic [8:0] freqHz,
    input wire logic [7:0] ampVolts,
    input wire logic [1:0] signalForm,
    input wire logic [8:0] savedFreq,
    input wire logic [7:0] savedAmp,
    input wire logic [1:0] savedForm,
    input wire logic       saveStrobe,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // drive and indicator come from one state, so they never part
    AST_RUN_LED: assert property (runLed == pumpDrive)
        else $error("run indicator differs from drive");
    AST_FREQ_RANGE: assert property (freqHz >= 9'h001 && freqHz <= 9'h12c)
        else $error("frequency left its range");
    AST_AMP_RANGE: assert property (ampVolts inside {[8'h01:8'hfa]})
        else $error("amplitude left its range");
    AST_FORM_LEGAL: assert property (signalForm != 2'h3)
        else $error("unknown signal form code");
    AST_SAVE_COPY: assert property (saveStrobe |-> savedFreq == $past(freqHz)
        && savedAmp == $past(ampVolts) && savedForm == $past(signalForm))
        else $error("saved copy differs from settings");
    AST_SAVE_PULSE: assert property (saveStrobe |=> !saveStrobe)
        else $error("save strobe longer than one cycle");
    // window covers the switch synchroniser latency
    AST_RUN_TOGGLE: assert property ($rose(swRun) |-> ##[2:8] $changed(pumpDrive))
        else $error("run press did not toggle drive");
    AST_SIG_WRAP: assert property ($rose(swSignal) && signalForm == 2'h2 |->
        ##[2:8] signalForm == 2'h0)
        else $error("sine did not wrap to shaped form");
    AST_FREQ_DN: assert property ($rose(swFreqDn) && freqHz != 9'h001 |->
        ##[2:8] $changed(freqHz))
        else $error("frequency down press had no effect");
    cover property (saveStrobe);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (pumpDrive && $changed(signalForm));
endmodule : pcp_panel_chk
bind pcp_command_panel pcp_panel_chk u_chk (
    .core_clk(core_clk), .arst_n(arst_n), .swRun(swRun), .swSignal(swSignal),
    .swFreqDn(swFreqDn), .pumpDrive(pumpDrive), .runLed(runLed), .freqHz(freqHz),
    .ampVolts(ampVolts), .signalForm(signalForm), .savedFreq(savedFreq),
    .savedAmp(savedAmp), .savedForm(savedForm), .saveStrobe(saveStrobe),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid)
);
`default_nettype wire

// ---- tb/test_pump_controller_command_panel.sv ----
// self-checking bench for the pump command panel
`timescale 1ns/1ps
`default_nettype none
module test_pump_controller_command_panel import pcp_pkg::*;;
    logic        core_clk, arst_n, awvalid, wvalid, bready, arvalid, rready, serTxd;
    logic        pumpDrive, runLed, saveStrobe, awready, wready, bvalid, arready, rvalid;
    wire         serRxd;
    logic [6:0]  sw;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, form, sForm, em;
    logic [8:0]  freq, sFreq, ef;
    logic [7:0]  amp, sAmp, ea, lf;
    logic [33:0] exq[$];
    int          miscompares, checks;
    pcp_host_term i_host (.rxd(serRxd));
    pcp_command_panel i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .serRxd(serRxd), .serTxd(serTxd),
        .swRun(sw[0]), .swSave(sw[1]), .swSignal(sw[2]), .swFreqUp(sw[3]),
        .swFreqDn(sw[4]), .swAmpUp(sw[5]), .swAmpDn(sw[6]), .pumpDrive(pumpDrive),
        .runLed(runLed), .freqHz(freq), .ampVolts(amp), .signalForm(form),
        .savedFreq(sFreq), .savedAmp(sAmp), .savedForm(sForm), .saveStrobe(saveStrobe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // results are matched in order against the oldest note
    always @(posedge core_clk) begin
        if (rvalid && rready) check({rresp, rdata}, exq.pop_front());
        if (bvalid && bready) check({bresp, 32'h0}, exq.pop_front());
        if (saveStrobe) check({15'h0, sFreq, sAmp, sForm}, exq.pop_front());
    end
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        exq.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        exq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    task automatic rall;
        rd(5'h04, {25'h0, ef});
        rd(5'h08, {26'h0, ea});
        rd(5'h0c, {32'h0, em});
    endtask : rall
    // held long enough to pass the switch synchroniser
    task automatic press(input int i);
        sw[i] <= 1'b1;
        repeat (10) @(posedge core_clk);
        sw[i] <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask : press
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // serial traffic dominates the run time, about 85k cycles
    initial begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
    initial begin
        sw = 7'h0; awaddr = 5'h0; araddr = 5'h0; wdata = 32'h0; awvalid = 1'b0;
        wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0; arst_n = 1'b0;
        miscompares = 0; checks = 0; lf = 8'h39;
        ef = 9'h064; ea = 8'h64; em = PCP_FORM_SINE;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rall();
        rd(5'h14, {2'h2, 32'h0});
        wr(5'h14, 32'h1, 2'h2);
        $display("test reset and map done");
        wr(5'h04, 32'h12c, 2'h0);
        ef = 9'h12c;
        press(3);
        wr(5'h04, 32'h12d, 2'h0);
        press(4);
        press(4);
        press(3);
        ef = 9'h12b;
        wr(5'h04, 32'h0, 2'h0);
        rall();
        $display("test frequency done");
        for (int k = 0; k < 4; k++) begin
            lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            ea = 8'(lf % 8'd250 + 8'd1);
            wr(5'h08, {24'h0, ea}, 2'h0);
            press(5);
            if (ea != 8'hfa) ea++;
            rall();
            press(6);
            if (ea != 8'h01) ea--;
            rall();
        end
        $display("test amplitude done");
        for (int k = 0; k < 3; k++) begin
            press(2);
            em = (em == 2'h2) ? 2'h0 : em + 2'h1;
            rall();
        end
        $display("test signal cycle done");
        press(0);
        check({33'h0, pumpDrive}, 34'h1);
        rd(5'h00, 34'h1);
        press(2);
        em = PCP_FORM_SHAPED;
        exq.push_back({15'h0, ef, ea, em});
        press(1);
        press(0);
        rd(5'h00, 34'h0);
        wr(5'h00, 32'h1, 2'h0);
        rd(5'h00, 34'h1);
        $display("test run and save done");
        i_host.send("MR");
        rall();
        i_host.send("\015");
        em = PCP_FORM_RECT;
        repeat (5) @(posedge core_clk); // acts in cycles, not 100 ms
        rall();
        i_host.send("\015");
        repeat (5) @(posedge core_clk);
        check({33'h0, serTxd}, 34'h0);
        rd(5'h10, 34'h5);
        $display("test serial command done");
        final_report();
    end
endmodule : test_pump_controller_command_panel
`default_nettype wire
